// ==== verilog/rph_pkg.sv ====
// Constants, types and helper functions of the packet handling block
package rph_pkg;

  localparam logic [15:0] ADDR_FRAME_SIZE_LIMIT = 16'hdf02;
  localparam logic [15:0] ADDR_PACKET_CONTROL_PRIMARY = 16'hdf03;
  localparam logic [15:0] ADDR_PACKET_CONTROL_SECONDARY = 16'hdf04;
  localparam logic [15:0] ADDR_OWN_STATION = 16'hdf05;

  localparam logic [7:0] RST_FRAME_SIZE_LIMIT = 8'hff;
  localparam logic [7:0] RST_PACKET_CONTROL_PRIMARY = 8'h04;
  localparam logic [7:0] RST_PACKET_CONTROL_SECONDARY = 8'h45;
  localparam logic [7:0] RST_OWN_STATION = 8'h00;

  // Writable bits; the rest read as zero
  localparam logic [7:0] MASK_PACKET_CONTROL_PRIMARY = 8'he7;
  localparam logic [7:0] MASK_PACKET_CONTROL_SECONDARY = 8'h7f;

  localparam int PQ_THR_MSB = 7;
  localparam int PQ_THR_LSB = 5;
  localparam int STATUS_TRAILER_BIT = 2;
  localparam int ADDR_FILTER_MSB = 1;
  localparam int ADDR_FILTER_LSB = 0;
  localparam int SCRAMBLE_BIT = 6;
  localparam int FORMAT_MSB = 5;
  localparam int FORMAT_LSB = 4;
  localparam int LEGACY_CRC_BIT = 3;
  localparam int CRC_ENABLE_BIT = 2;
  localparam int LENGTH_MSB = 1;
  localparam int LENGTH_LSB = 0;

  localparam logic [4:0] PQ_MAX = 5'h1f;
  localparam logic [4:0] PQ_DEC = 5'h04;
  localparam logic [4:0] PQ_INC = 5'h01;

  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hff;

  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_NATIVE = 16'h8005;
  localparam logic [15:0] CRC_POLY_LEGACY = 16'h1021;
  localparam logic [8:0] PN9_SEED = 9'h1ff;

  typedef enum logic [1:0] {
    FMT_NORMAL = 2'h0,
    FMT_SERIAL_SYNC = 2'h1,
    FMT_PN9_TEST = 2'h2,
    FMT_ASYNC = 2'h3
  } rph_fmt_t;

  typedef enum logic [1:0] {
    LEN_FIXED = 2'h0,
    LEN_VARIABLE = 2'h1,
    LEN_INFINITE = 2'h2,
    LEN_RESERVED = 2'h3
  } rph_len_t;

  typedef enum logic [1:0] {
    AF_NONE = 2'h0,
    AF_NO_BCAST = 2'h1,
    AF_BCAST_ZERO = 2'h2,
    AF_BCAST_BOTH = 2'h3
  } rph_af_t;

  // MSB-first CRC-16 over one byte
  function automatic logic [15:0] rph_crc_byte(input logic [15:0] crc, input logic [7:0] data,
                                              input logic [15:0] poly);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ data[i]) ? ({c[14:0], 1'b0} ^ poly) : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // PN9 (x^9 + x^5 + 1) advanced by eight steps
  function automatic logic [8:0] rph_pn9_step8(input logic [8:0] s);
    logic [8:0] v;
    v = s;
    for (int i = 0; i < 8; i++) begin
      v = {v[0] ^ v[5], v[8:1]};
    end
    return v;
  endfunction

endpackage

// ==== verilog/rph_pq_if.sv ====
// Interface between the framer and the preamble quality gate
`timescale 1ns/1ns
`default_nettype none
interface rph_pq_if;
  logic bit_valid;
  logic bit_value;
  logic [2:0] threshold;
  logic sync_raw;
  logic sync_accept;
  logic [4:0] quality;

  modport gate (input bit_valid, input bit_value, input threshold, input sync_raw,
                output sync_accept, output quality);
  modport user (output bit_valid, output bit_value, output threshold, output sync_raw,
                input sync_accept, input quality);
endinterface
`default_nettype wire

// ==== verilog/rph_preamble_gate.sv ====
// Preamble quality estimator gating sync word detection
`timescale 1ns/1ns
`default_nettype none
module rph_preamble_gate
  import rph_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  rph_pq_if.gate pq
);

  typedef struct packed {
    logic [4:0] q;
    logic prev;
    logic have_prev;
  } rph_pq_state_t;

  rph_pq_state_t st_ff;
  rph_pq_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (pq.bit_valid) begin
      nxt_st.prev = pq.bit_value;
      nxt_st.have_prev = 1'b1;
      if (st_ff.have_prev) begin
        if (pq.bit_value != st_ff.prev) begin
          nxt_st.q = (st_ff.q == PQ_MAX) ? PQ_MAX : st_ff.q + PQ_INC;
        end else begin
          nxt_st.q = (st_ff.q < PQ_DEC) ? 5'h00 : st_ff.q - PQ_DEC;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Threshold of zero lets every sync word through
  assign pq.sync_accept = pq.sync_raw && ((pq.threshold == 3'h0) || (st_ff.q >= {pq.threshold, 2'b00}));
  assign pq.quality = st_ff.q;

endmodule
`default_nettype wire

// ==== verilog/rph_framer.sv ====
// Packet framer: length, address filter, CRC, whitening, status trailer and data format select
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Fixed length: limit is exact payload length; resets 0xff.
// - Variable length: limit is largest allowed length.
// - Quality counter +1 on change, -4 on repeat, saturates 0..31.
// - Sync accepted at counter >= 4*threshold; zero accepts all.
// - Trailer enable appends RSSI byte and CRC-ok/LQI byte.
// - Address filter: none, exact, plus 0x00, plus 0x00 and 0xff.
// - Secondary bit 6 enables whitening, resets to one.
// - Format 00 uses the FIFOs.
// - Format 01 is serial synchronous.
// - Format 10 sends PN9 data; receives as normal.
// - Format 11 is transparent: tx from pin zero, rx mirrored out.
// - Legacy CRC bit selects the older polynomial.
// - Checksum enable makes CRC on transmit, checks on receive.
// - Length policy 00 is fixed length.
// - Length policy 01 takes length from first byte after sync.
// - Length policy 10 is infinite; 11 reserved.
// - Address filter compares with own station register, reset zero.
module rph_framer
  import rph_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic sync_raw,
  output logic sync_accept,
  output logic [4:0] preamble_quality,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] rssi,
  input wire logic [6:0] lqi,
  input wire logic link_abort,
  output logic rxf_valid,
  output logic [7:0] rxf_data,
  output logic rxf_discard,
  output logic rx_done,
  output logic rx_crc_ok,
  input wire logic tx_start,
  input wire logic txf_valid,
  input wire logic [7:0] txf_data,
  output logic txf_ready,
  output logic tx_byte_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_byte_ready,
  output logic tx_done,
  output logic fifo_path_en,
  output logic serial_sync_en,
  output logic async_en,
  input wire logic general_out_zero,
  output logic async_tx_bit,
  output logic async_rx_out
);

  typedef enum logic [2:0] {RX_IDLE, RX_LEN, RX_ADDR, RX_PAY, RX_CRC_HI, RX_CRC_LO, RX_ST_RSSI, RX_ST_LQI} rph_rx_t;
  typedef enum logic [2:0] {TX_IDLE, TX_LEN, TX_PAY, TX_CRC_HI, TX_CRC_LO, TX_PN9} rph_tx_t;

  typedef struct packed {
    logic [7:0] limit;
    logic [7:0] ctl_pri;
    logic [7:0] ctl_sec;
    logic [7:0] station;
    logic [7:0] rd;
    rph_rx_t rx_st;
    logic [7:0] rcnt;
    logic [15:0] rcrc;
    logic [8:0] rwh;
    logic rv;
    logic [7:0] rdat;
    logic rdisc;
    logic rdone;
    logic crc_ok;
    rph_tx_t tx_st;
    logic [7:0] tcnt;
    logic [15:0] tcrc;
    logic [8:0] twh;
    logic [8:0] pn;
    logic tv;
    logic [7:0] tdat;
    logic tdone;
    logic pin_s1;
    logic pin_s2;
    logic arx;
  } rph_state_t;

  rph_state_t st_ff;
  rph_state_t nxt_st;

  rph_pq_if pq_bus ();

  rph_fmt_t fmt;
  rph_len_t len_pol;
  rph_af_t af;
  logic scramble_on;
  logic crc_on;
  logic trailer_on;
  logic infinite;
  logic [15:0] poly;
  logic [7:0] rx_plain;
  logic [15:0] rx_crc_upd;
  logic addr_pass;
  logic slot_free;
  logic [7:0] tx_raw;
  logic tx_emit;

  assign fmt = rph_fmt_t'(st_ff.ctl_sec[FORMAT_MSB:FORMAT_LSB]);
  assign len_pol = rph_len_t'(st_ff.ctl_sec[LENGTH_MSB:LENGTH_LSB]);
  assign af = rph_af_t'(st_ff.ctl_pri[ADDR_FILTER_MSB:ADDR_FILTER_LSB]);
  assign scramble_on = st_ff.ctl_sec[SCRAMBLE_BIT];
  assign crc_on = st_ff.ctl_sec[CRC_ENABLE_BIT];
  assign trailer_on = st_ff.ctl_pri[STATUS_TRAILER_BIT];
  // Reserved policy is run as fixed length rather than left undefined
  assign infinite = (len_pol == LEN_INFINITE);
  // Whitening stays under software control; no interlock against the legacy CRC bit
  assign poly = st_ff.ctl_sec[LEGACY_CRC_BIT] ? CRC_POLY_LEGACY : CRC_POLY_NATIVE;

  assign pq_bus.bit_valid = rx_bit_valid;
  assign pq_bus.bit_value = rx_bit;
  assign pq_bus.threshold = st_ff.ctl_pri[PQ_THR_MSB:PQ_THR_LSB];
  assign pq_bus.sync_raw = sync_raw;

  rph_preamble_gate u_gate (
    .clk(clk),
    .srst(srst),
    .pq(pq_bus)
  );

  assign rx_plain = rx_byte ^ (scramble_on ? st_ff.rwh[7:0] : 8'h00);
  assign rx_crc_upd = rph_crc_byte(st_ff.rcrc, rx_plain, poly);

  always_comb begin
    unique case (af)
      AF_NONE: addr_pass = 1'b1;
      AF_NO_BCAST: addr_pass = (rx_plain == st_ff.station);
      AF_BCAST_ZERO: addr_pass = (rx_plain == st_ff.station) || (rx_plain == BCAST_ZERO);
      AF_BCAST_BOTH: addr_pass = (rx_plain == st_ff.station) || (rx_plain == BCAST_ZERO)
                                 || (rx_plain == BCAST_ONES);
    endcase
  end

  assign slot_free = !st_ff.tv || tx_byte_ready;
  assign txf_ready = slot_free && ((st_ff.tx_st == TX_LEN) || (st_ff.tx_st == TX_PAY));
  assign tx_emit = txf_valid && txf_ready;
  assign tx_raw = txf_data;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rv = 1'b0;
    nxt_st.rdisc = 1'b0;
    nxt_st.rdone = 1'b0;
    nxt_st.tdone = 1'b0;

    // Register port; reads answer one cycle later
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_FRAME_SIZE_LIMIT: nxt_st.limit = reg_wdata;
        ADDR_PACKET_CONTROL_PRIMARY: nxt_st.ctl_pri = reg_wdata & MASK_PACKET_CONTROL_PRIMARY;
        ADDR_PACKET_CONTROL_SECONDARY: nxt_st.ctl_sec = reg_wdata & MASK_PACKET_CONTROL_SECONDARY;
        ADDR_OWN_STATION: nxt_st.station = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_FRAME_SIZE_LIMIT: nxt_st.rd = st_ff.limit;
        ADDR_PACKET_CONTROL_PRIMARY: nxt_st.rd = st_ff.ctl_pri;
        ADDR_PACKET_CONTROL_SECONDARY: nxt_st.rd = st_ff.ctl_sec;
        ADDR_OWN_STATION: nxt_st.rd = st_ff.station;
        default: nxt_st.rd = 8'h00;
      endcase
    end

    // Receive path, used by normal and PN9 formats
    if (rx_byte_valid && (st_ff.rx_st inside {RX_LEN, RX_ADDR, RX_PAY, RX_CRC_HI, RX_CRC_LO})) begin
      nxt_st.rwh = rph_pn9_step8(st_ff.rwh);
      if (crc_on) begin
        nxt_st.rcrc = rx_crc_upd;
      end
    end
    unique case (st_ff.rx_st)
      RX_IDLE: begin
        if (pq_bus.sync_accept && fifo_path_en) begin
          nxt_st.rcrc = CRC_INIT;
          nxt_st.rwh = PN9_SEED;
          nxt_st.crc_ok = 1'b0;
          nxt_st.rcnt = st_ff.limit;
          if (len_pol == LEN_VARIABLE) begin
            nxt_st.rx_st = RX_LEN;
          end else if (!infinite && (st_ff.limit == 8'h00)) begin
            nxt_st.rx_st = crc_on ? RX_CRC_HI : (trailer_on ? RX_ST_RSSI : RX_IDLE);
            nxt_st.rdone = !crc_on && !trailer_on;
          end else begin
            nxt_st.rx_st = (af != AF_NONE) ? RX_ADDR : RX_PAY;
          end
        end
      end
      RX_LEN: begin
        if (rx_byte_valid) begin
          nxt_st.rv = 1'b1;
          nxt_st.rdat = rx_plain;
          nxt_st.rcnt = rx_plain;
          if (rx_plain > st_ff.limit) begin
            nxt_st.rdisc = 1'b1;
            nxt_st.rx_st = RX_IDLE;
          end else if (rx_plain == 8'h00) begin
            nxt_st.rx_st = crc_on ? RX_CRC_HI : (trailer_on ? RX_ST_RSSI : RX_IDLE);
            nxt_st.rdone = !crc_on && !trailer_on;
          end else begin
            nxt_st.rx_st = (af != AF_NONE) ? RX_ADDR : RX_PAY;
          end
        end
      end
      RX_ADDR, RX_PAY: begin
        if (rx_byte_valid) begin
          nxt_st.rv = 1'b1;
          nxt_st.rdat = rx_plain;
          if (!infinite) begin
            nxt_st.rcnt = st_ff.rcnt - 8'h01;
          end
          if ((st_ff.rx_st == RX_ADDR) && !addr_pass) begin
            nxt_st.rv = 1'b0;
            nxt_st.rdisc = 1'b1;
            nxt_st.rx_st = RX_IDLE;
          end else if (!infinite && (st_ff.rcnt == 8'h01)) begin
            nxt_st.rx_st = crc_on ? RX_CRC_HI : (trailer_on ? RX_ST_RSSI : RX_IDLE);
            nxt_st.rdone = !crc_on && !trailer_on;
          end else begin
            nxt_st.rx_st = RX_PAY;
          end
        end
      end
      RX_CRC_HI: begin
        if (rx_byte_valid) begin
          nxt_st.rx_st = RX_CRC_LO;
        end
      end
      RX_CRC_LO: begin
        if (rx_byte_valid) begin
          // Running the received checksum through the register leaves zero on a good packet
          nxt_st.crc_ok = (rx_crc_upd == 16'h0000);
          nxt_st.rx_st = trailer_on ? RX_ST_RSSI : RX_IDLE;
          nxt_st.rdone = !trailer_on;
        end
      end
      RX_ST_RSSI: begin
        nxt_st.rv = 1'b1;
        nxt_st.rdat = rssi;
        nxt_st.rx_st = RX_ST_LQI;
      end
      RX_ST_LQI: begin
        nxt_st.rv = 1'b1;
        nxt_st.rdat = {st_ff.crc_ok, lqi};
        nxt_st.rdone = 1'b1;
        nxt_st.rx_st = RX_IDLE;
      end
    endcase
    if (link_abort && (st_ff.rx_st != RX_IDLE)) begin
      nxt_st.rv = 1'b0;
      nxt_st.rdone = 1'b0;
      nxt_st.rdisc = 1'b1;
      nxt_st.rx_st = RX_IDLE;
    end

    // Transmit path
    if (st_ff.tv && tx_byte_ready) begin
      nxt_st.tv = 1'b0;
    end
    unique case (st_ff.tx_st)
      TX_IDLE: begin
        if (tx_start) begin
          nxt_st.tcrc = CRC_INIT;
          nxt_st.twh = PN9_SEED;
          nxt_st.pn = PN9_SEED;
          nxt_st.tcnt = st_ff.limit;
          if (fmt == FMT_PN9_TEST) begin
            nxt_st.tx_st = TX_PN9;
          end else if (fmt == FMT_NORMAL) begin
            if (len_pol == LEN_VARIABLE) begin
              nxt_st.tx_st = TX_LEN;
            end else if (!infinite && (st_ff.limit == 8'h00)) begin
              nxt_st.tx_st = crc_on ? TX_CRC_HI : TX_IDLE;
              nxt_st.tdone = !crc_on;
            end else begin
              nxt_st.tx_st = TX_PAY;
            end
          end
        end
      end
      TX_LEN, TX_PAY: begin
        if (tx_emit) begin
          nxt_st.tv = 1'b1;
          nxt_st.tdat = tx_raw ^ (scramble_on ? st_ff.twh[7:0] : 8'h00);
          nxt_st.twh = rph_pn9_step8(st_ff.twh);
          nxt_st.tcrc = rph_crc_byte(st_ff.tcrc, tx_raw, poly);
          if (st_ff.tx_st == TX_LEN) begin
            nxt_st.tcnt = tx_raw;
          end else if (!infinite) begin
            nxt_st.tcnt = st_ff.tcnt - 8'h01;
          end
          if (((st_ff.tx_st == TX_LEN) && (tx_raw == 8'h00)) ||
              ((st_ff.tx_st == TX_PAY) && !infinite && (st_ff.tcnt == 8'h01))) begin
            nxt_st.tx_st = crc_on ? TX_CRC_HI : TX_IDLE;
            nxt_st.tdone = !crc_on;
          end else begin
            nxt_st.tx_st = TX_PAY;
          end
        end
      end
      TX_CRC_HI, TX_CRC_LO: begin
        if (slot_free) begin
          nxt_st.tv = 1'b1;
          nxt_st.tdat = ((st_ff.tx_st == TX_CRC_HI) ? st_ff.tcrc[15:8] : st_ff.tcrc[7:0])
                        ^ (scramble_on ? st_ff.twh[7:0] : 8'h00);
          nxt_st.twh = rph_pn9_step8(st_ff.twh);
          nxt_st.tx_st = (st_ff.tx_st == TX_CRC_HI) ? TX_CRC_LO : TX_IDLE;
          nxt_st.tdone = (st_ff.tx_st == TX_CRC_LO);
        end
      end
      TX_PN9: begin
        if (slot_free) begin
          nxt_st.tv = 1'b1;
          nxt_st.tdat = st_ff.pn[7:0];
          nxt_st.pn = rph_pn9_step8(st_ff.pn);
        end
      end
    endcase
    if (link_abort && (st_ff.tx_st != TX_IDLE)) begin
      nxt_st.tx_st = TX_IDLE;
      nxt_st.tdone = 1'b1;
    end

    // Transparent mode: pin sampled twice before use, rx bit mirrored out
    nxt_st.pin_s1 = general_out_zero;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.arx = async_en && rx_bit;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.limit <= RST_FRAME_SIZE_LIMIT;
      st_ff.ctl_pri <= RST_PACKET_CONTROL_PRIMARY;
      st_ff.ctl_sec <= RST_PACKET_CONTROL_SECONDARY;
      st_ff.station <= RST_OWN_STATION;
      st_ff.rx_st <= RX_IDLE;
      st_ff.tx_st <= TX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rd;
  assign sync_accept = pq_bus.sync_accept;
  assign preamble_quality = pq_bus.quality;
  assign rxf_valid = st_ff.rv;
  assign rxf_data = st_ff.rdat;
  assign rxf_discard = st_ff.rdisc;
  assign rx_done = st_ff.rdone;
  assign rx_crc_ok = st_ff.crc_ok;
  assign tx_byte_valid = st_ff.tv;
  assign tx_byte = st_ff.tdat;
  assign tx_done = st_ff.tdone;
  assign fifo_path_en = (fmt == FMT_NORMAL) || (fmt == FMT_PN9_TEST);
  assign serial_sync_en = (fmt == FMT_SERIAL_SYNC);
  assign async_en = (fmt == FMT_ASYNC);
  assign async_tx_bit = async_en && st_ff.pin_s2;
  assign async_rx_out = st_ff.arx;

endmodule
`default_nettype wire

// ==== sim/rph_modem_model.sv ====
// Modem side model: feeds received bits and bytes, sinks transmit bytes with optional stalls
`timescale 1ns/1ns
`default_nettype none
module rph_modem_model (
  input wire logic clk,
  input wire logic slow,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_byte_ready
);
  logic [7:0] txq [$];
  logic tgl_ff = 1'b0;
  initial begin
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // Lines show the inverse of the last value when idle, so stale data never looks valid
  task automatic send_bit(input logic b);
    @(negedge clk);
    rx_bit = b;
    rx_bit_valid = 1'b1;
    @(negedge clk);
    rx_bit_valid = 1'b0;
    rx_bit = ~b;
  endtask
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    rx_byte = b;
    rx_byte_valid = 1'b1;
    @(negedge clk);
    rx_byte_valid = 1'b0;
    rx_byte = ~b;
  endtask
  always @(negedge clk) tgl_ff <= ~tgl_ff;
  assign tx_byte_ready = slow ? tgl_ff : 1'b1;
  always @(posedge clk) begin
    if (tx_byte_valid === 1'b1 && tx_byte_ready) txq.push_back(tx_byte);
  end
endmodule
`default_nettype wire

// ==== sim/rph_framer_properties.sv ====
// Port-level checker for the packet framer
`timescale 1ns/1ns
`default_nettype none
module rph_framer_chk
  import rph_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic sync_raw,
  input wire logic sync_accept,
  input wire logic [4:0] preamble_quality,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_ready,
  input wire logic link_abort,
  input wire logic serial_sync_en,
  input wire logic async_en,
  input wire logic async_rx_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [2:0] pqt_ff;
  logic [1:0] fmt_ff;
  logic last_ff;
  logic seen_ff;
  // Shadow copies of the fields that gate outputs combinationally
  always_ff @(posedge clk) begin
    if (srst) begin
      pqt_ff <= 3'h0;
      fmt_ff <= 2'h0;
      last_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_PACKET_CONTROL_PRIMARY) pqt_ff <= reg_wdata[7:5];
      if (reg_wr && reg_addr == ADDR_PACKET_CONTROL_SECONDARY) fmt_ff <= reg_wdata[5:4];
      if (rx_bit_valid) begin
        last_ff <= rx_bit;
        seen_ff <= 1'b1;
      end
    end
  end
  property p_unmapped_read;
    reg_rd && (reg_addr < ADDR_FRAME_SIZE_LIMIT || reg_addr > ADDR_OWN_STATION) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
  property p_rsv_primary;
    reg_rd && reg_addr == ADDR_PACKET_CONTROL_PRIMARY |=> reg_rdata[4:3] == 2'h0;
  endproperty
  a_rsv_primary: assert property (p_rsv_primary) else $error("primary reserved bits set");
  property p_rsv_secondary;
    reg_rd && reg_addr == ADDR_PACKET_CONTROL_SECONDARY |=> !reg_rdata[7];
  endproperty
  a_rsv_secondary: assert property (p_rsv_secondary) else $error("secondary reserved bit set");
  property p_pq_up;
    rx_bit_valid && seen_ff && rx_bit != last_ff |=>
      preamble_quality == (($past(preamble_quality) == 5'h1f) ? 5'h1f : $past(preamble_quality) + 5'h01);
  endproperty
  a_pq_up: assert property (p_pq_up) else $error("quality step up wrong");
  property p_pq_down;
    rx_bit_valid && seen_ff && rx_bit == last_ff |=>
      preamble_quality == (($past(preamble_quality) < 5'h04) ? 5'h00 : $past(preamble_quality) - 5'h04);
  endproperty
  a_pq_down: assert property (p_pq_down) else $error("quality step down wrong");
  property p_sync_gate;
    sync_accept == (sync_raw && (pqt_ff == 3'h0 || preamble_quality >= {pqt_ff, 2'b00}));
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync gating wrong");
  property p_fmt_levels;
    async_en == (fmt_ff == 2'h3) && serial_sync_en == (fmt_ff == 2'h1);
  endproperty
  a_fmt_levels: assert property (p_fmt_levels) else $error("format enables wrong");
  property p_async_rx;
    async_rx_out == ($past(async_en) && $past(rx_bit));
  endproperty
  a_async_rx: assert property (p_async_rx) else $error("async rx output wrong");
  property p_tx_hold;
    tx_byte_valid && !tx_byte_ready && !link_abort |=> tx_byte_valid && $stable(tx_byte);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped while stalled");
endmodule
bind rph_framer rph_framer_chk u_rph_framer_chk (.*);
`default_nettype wire

// ==== sim/rph_framer_tb.sv ====
// Register-driven testbench of the packet framer
`timescale 1ns/1ns
`default_nettype none
module rph_framer_tb;
  import rph_pkg::*;
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, sync_raw = 0, tx_start = 0, txf_valid = 0, goz = 0, slow = 0;
  logic [15:0] reg_addr = 0, c;
  logic [7:0] reg_wdata = 0, txf_data = 0, rssi = 8'h5a, reg_rdata, rxf_data, tx_byte, rx_byte;
  logic [6:0] lqi = 7'h33;
  logic sync_accept, rxf_valid, rxf_discard, rx_done, rx_crc_ok, txf_ready, tx_byte_valid, tx_byte_ready, tx_done;
  logic fifo_path_en, serial_sync_en, async_en, async_tx_bit, async_rx_out, rx_bit_valid, rx_bit, rx_byte_valid, ok;
  logic [4:0] preamble_quality;
  logic [7:0] rxq [$];
  logic [7:0] av [4] = '{8'h12, 8'h00, 8'hff, 8'h34};
  int err_total = 0, checked = 0, n_disc, n_done, n_txd;
  always #50 clk = ~clk;
  rph_framer u_rph_framer (.link_abort(1'b0), .general_out_zero(goz), .*);
  rph_modem_model u_rph_modem_model (.*);
  always @(posedge clk) begin
    if (rxf_valid === 1'b1) rxq.push_back(rxf_data);
    if (rxf_discard === 1'b1) n_disc++;
    if (rx_done === 1'b1) n_done++;
    if (tx_done === 1'b1) n_txd++;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    chk(nm, reg_rdata, exp);
  endtask
  // Independent reference, MSB first, no final inversion
  function automatic logic [15:0] crc_ref(input logic [15:0] s, input logic [7:0] d, input logic [15:0] p);
    for (int i = 7; i >= 0; i--) s = {s[14:0], 1'b0} ^ ((s[15] ^ d[i]) ? p : 16'h0000);
    return s;
  endfunction
  task automatic rx_pkt(input logic [7:0] b [$]);
    rxq.delete();
    n_disc = 0;
    n_done = 0;
    @(negedge clk) sync_raw = 1;
    @(negedge clk) sync_raw = 0;
    foreach (b[i]) u_rph_modem_model.send_byte(b[i]);
    repeat (6) @(negedge clk);
  endtask
  task automatic tx_pkt(input logic [7:0] d);
    int n;
    u_rph_modem_model.txq.delete();
    n_txd = 0;
    n = 0;
    @(negedge clk) tx_start = 1;
    @(negedge clk) tx_start = 0;
    txf_valid = 1;
    txf_data = d;
    while (txf_ready !== 1'b1 && n++ < 20) @(negedge clk);
    @(negedge clk) txf_valid = 0;
    repeat (20) @(negedge clk);
  endtask
  initial begin
    #5000000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (6) @(negedge clk);
    srst = 0;
    rd_chk("frame_size_limit", 16'hdf02, 8'hff);
    rd_chk("packet_control_primary", 16'hdf03, 8'h04);
    rd_chk("packet_control_secondary", 16'hdf04, 8'h45);
    rd_chk("own_station", 16'hdf05, 8'h00);
    rd_chk("unmapped", 16'hdf06, 8'h00);
    wr(16'hdf03, 8'hff);
    rd_chk("primary_reserved", 16'hdf03, 8'he7);
    wr(16'hdf04, 8'hb7);
    rd_chk("secondary_reserved", 16'hdf04, 8'h37);
    $display("test registers done");
    for (int f = 0; f < 4; f++) begin
      wr(16'hdf04, {2'b00, f[1:0], 4'h0});
      chk("fifo_path_en", fifo_path_en, f == 0 || f == 2);
      chk("serial_sync_en", serial_sync_en, f == 1);
      chk("async_en", async_en, f == 3);
      u_rph_modem_model.send_bit(1'b1);
      if (f == 3) begin
        goz = 1;
        repeat (4) @(negedge clk);
        chk("async_tx_bit", async_tx_bit, 1'b1);
        goz = 0;
        repeat (4) @(negedge clk);
        chk("async_tx_bit", async_tx_bit, 1'b0);
      end
    end
    $display("test formats done");
    wr(16'hdf03, 8'h00);
    wr(16'hdf04, 8'h01);
    wr(16'hdf02, 8'hff);
    rx_pkt('{8'h02, 8'ha5, 8'h3c});
    chk("var_written", rxq.size(), 3);
    chk("var_last", rxq[2], 8'h3c);
    chk("var_done", n_done, 1);
    wr(16'hdf02, 8'h01);
    rx_pkt('{8'h02, 8'ha5, 8'h3c});
    chk("var_over_discard", n_disc, 1);
    chk("var_over_written", rxq.size(), 1);
    wr(16'hdf04, 8'h00);
    wr(16'hdf02, 8'h02);
    rx_pkt('{8'h11, 8'h22, 8'h33});
    chk("fixed_written", rxq.size(), 2);
    chk("fixed_last", rxq[1], 8'h22);
    wr(16'hdf04, 8'h20);
    rx_pkt('{8'h11, 8'h22});
    chk("pn9_rx_written", rxq.size(), 2);
    $display("test length done");
    wr(16'hdf04, 8'h00);
    wr(16'hdf05, 8'h12);
    for (int m = 0; m < 4; m++) begin
      wr(16'hdf03, m[7:0]);
      foreach (av[k]) begin
        ok = m == 0 || av[k] == 8'h12 || (m > 1 && av[k] == 8'h00) || (m == 3 && av[k] == 8'hff);
        rx_pkt('{av[k], 8'h77});
        chk("af_written", rxq.size(), ok ? 2 : 0);
        chk("af_discard", n_disc, ok ? 0 : 1);
      end
    end
    $display("test address done");
    wr(16'hdf02, 8'h01);
    wr(16'hdf03, 8'h04);
    for (int l = 0; l < 2; l++) begin
      wr(16'hdf04, l ? 8'h0c : 8'h04);
      c = crc_ref(16'hffff, 8'h5e, l ? 16'h1021 : 16'h8005);
      rx_pkt('{8'h5e, c[15:8], c[7:0]});
      chk("trailer_count", rxq.size(), 3);
      chk("trailer_rssi", rxq[1], rssi);
      chk("trailer_lqi", rxq[2], {1'b1, lqi});
      chk("crc_ok", rx_crc_ok, 1'b1);
      chk("trailer_done", n_done, 1);
      rx_pkt('{8'h5e, c[15:8], ~c[7:0]});
      chk("crc_bad", rx_crc_ok, 1'b0);
    end
    $display("test crc done");
    wr(16'hdf04, 8'h00);
    wr(16'hdf03, 8'h20);
    repeat (8) u_rph_modem_model.send_bit(1'b0);
    chk("pq_floor", preamble_quality, 5'h00);
    rx_pkt('{8'h99});
    chk("pq_gated", rxq.size(), 0);
    for (int i = 0; i < 40; i++) u_rph_modem_model.send_bit(~i[0]);
    chk("pq_ceiling", preamble_quality, 5'h1f);
    u_rph_modem_model.send_bit(1'b0);
    chk("pq_minus4", preamble_quality, 5'h1b);
    rx_pkt('{8'h99});
    chk("pq_open", rxq.size(), 1);
    $display("test preamble done");
    for (int t = 0; t < 2; t++) begin
      wr(16'hdf04, t ? 8'h04 : 8'h40);
      slow = t;
      tx_pkt(8'hc3);
      c = crc_ref(16'hffff, 8'hc3, 16'h8005);
      if (t == 0) begin
        chk("tx_white_count", u_rph_modem_model.txq.size(), 1);
        chk("tx_white_byte", u_rph_modem_model.txq[0], 8'h3c);
      end else begin
        chk("tx_crc_count", u_rph_modem_model.txq.size(), 3);
        chk("tx_data", u_rph_modem_model.txq[0], 8'hc3);
        chk("tx_crc_hi", u_rph_modem_model.txq[1], c[15:8]);
        chk("tx_crc_lo", u_rph_modem_model.txq[2], c[7:0]);
      end
      chk("tx_done", n_txd, 1);
    end
    $display("test transmit done");
    conclude();
  end
endmodule
`default_nettype wire
